// [hdl/mct_pkg.sv]
// shared constants and carrier types for the maintenance command translator
`default_nettype none
package mct_pkg;
  // timing: blanking interval spans two phases (phase one to phase three)
  localparam int CLK_PERIOD_NS = 25;
  localparam int BLANK_NS = 2000;
  localparam int PHASE_CYC = BLANK_NS / (2 * CLK_PERIOD_NS);
  localparam logic [5:0] PHASE_LAST = 6'(PHASE_CYC - 1);

  // instruction word layout: bit 0 is instr_line_first, bit 8 is instr_line_last
  localparam int INSTR_LINE_FIRST = 0;
  localparam int INSTR_LINE_LAST = 8;
  localparam int GRP_LSB = 6;
  localparam int HOR_LSB = 3;
  localparam int VER_LSB = 0;

  // matrix groups feeding each downstream circuit
  localparam logic [2:0] GRP_TRANSFER = 3'h0;
  localparam logic [2:0] GRP_TIMER = 3'h1;
  localparam logic [2:0] GRP_TPREAD = 3'h2;
  localparam logic [2:0] GRP_ALARM = 3'h3;
  localparam logic [2:0] GRP_TESTCALL = 3'h4;
  localparam logic [2:0] ALARM_H_LIMIT = 3'h5;
  localparam logic [2:0] TESTCALL_H_LIMIT = 3'h4;
  localparam logic [2:0] TIMER_ADV_H = 3'h0;
  localparam logic [2:0] TIMER_ADV_V = 3'h0;
  localparam int TC_HIGH_GRP_BIT = 0;
  localparam int TC_TONE_BIT = 1;

  // register map (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_LASTCMD = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hc;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int STAT_IN0_LSB = 0;
  localparam int STAT_IN1_LSB = 9;
  localparam int STAT_FLAG0_LSB = 18;
  localparam int STAT_FLAG1_LSB = 22;
  localparam int STAT_PHASE_LSB = 26;
  localparam int STAT_SIDE_BIT = 28;
  localparam int COUNT_REJ_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // three-phase clock sequencer
  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b10
  } mct_phase_t;

  // per-translator state
  typedef struct packed {
    logic pend;
    logic loaded;
    logic issued;
    logic blank;
    logic win;
    logic [8:0] in_reg;
  } mct_side_t;

  // decoded command bundle to the maintenance center
  typedef struct packed {
    logic valid;
    logic [4:0] target;
    logic [2:0] hor;
    logic [2:0] ver;
    logic timer_advance;
    logic tone_digit_select;
    logic pulse_digit_select;
    logic any_digit_select;
    logic low_digit_group;
    logic high_digit_group;
    logic [7:0] digit_position_line;
  } mct_cmd_t;
endpackage
`default_nettype wire

// [hdl/mct_translator.sv]
// maintenance command translator pair with three-phase sequencer and register slave
//
// Behaviour
// - nine lines, three groups, each latched
// - three groups pick one of 264 points
// - load strobe copies instruction into input flops
// - loaded flops enable decoders, command partially
// - strobe active blocks phase-two input clear
// - load at phase one, enable at three
// - decoder outputs inert until command enable
// - phase one sets blank flop until three
// - blank clear at three fires command
// - phase one to three is two microseconds
// - command spans phase three to next one
// - inputs cleared at next phase two
// - two translators, one per program control
// - only active side translator issues commands
// - every downstream circuit gets decoded command
// - timer command advances control switchover
// - tone or pulse digit select lines
// - any-digit select follows either select
// - digit as group line plus position line
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`default_nettype none
module mct_translator
  import mct_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0][8:0] instr_lines, // per side, bit 0 = instr_line_first
  input wire logic [1:0] translator_load_strobe, // per side, active high
  input wire logic active_side_enable, // low selects side 0, high side 1
  output mct_cmd_t cmd,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // whole module state in one record
  typedef struct packed {
    logic [1:0][8:0] instr_s1; // first sync stage, read only by second
    logic [1:0][8:0] instr_s2;
    logic [1:0] strb_s1;
    logic [1:0] strb_s2;
    logic [1:0] strb_d; // for rising-edge detect
    logic act_s1;
    logic act_s2;
    mct_phase_t phase;
    logic [5:0] cnt;
    mct_side_t [1:0] side;
    mct_cmd_t cmd;
    logic ctrl_en; // software output enable
    logic [9:0] last_code; // side and code of last fired command
    logic [15:0] cnt_issued;
    logic [15:0] cnt_reject;
    logic aw_rdy;
    logic w_rdy;
    logic have_aw;
    logic have_w;
    logic [3:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } mct_state_t;

  mct_state_t st_r;
  mct_state_t st_nxt;

  // which matrix points exist as commands
  function automatic logic mct_is_impl(input logic [8:0] code);
    logic [2:0] g;
    logic [2:0] h;
    g = code[GRP_LSB +: 3];
    h = code[HOR_LSB +: 3];
    case (g)
      GRP_TRANSFER, GRP_TIMER, GRP_TPREAD: mct_is_impl = 1'b1;
      GRP_ALARM: mct_is_impl = (h < ALARM_H_LIMIT);
      GRP_TESTCALL: mct_is_impl = (h < TESTCALL_H_LIMIT);
      default: mct_is_impl = 1'b0;
    endcase
  endfunction

  // full decode of one crosspoint to the downstream lines
  function automatic mct_cmd_t mct_decode(input logic [8:0] code);
    mct_cmd_t c;
    logic [2:0] g;
    logic [2:0] h;
    logic [2:0] v;
    c = '0;
    g = code[GRP_LSB +: 3];
    h = code[HOR_LSB +: 3];
    v = code[VER_LSB +: 3];
    if (mct_is_impl(code)) begin
      c.valid = 1'b1;
      c.target = 5'(5'h01 << g);
      c.hor = h;
      c.ver = v;
      // timer point pulls the control switchover forward
      c.timer_advance = (g == GRP_TIMER) && (h == TIMER_ADV_H) && (v == TIMER_ADV_V);
      if (g == GRP_TESTCALL) begin
        c.tone_digit_select = h[TC_TONE_BIT];
        c.pulse_digit_select = !h[TC_TONE_BIT];
        c.any_digit_select = c.tone_digit_select | c.pulse_digit_select;
        c.low_digit_group = !h[TC_HIGH_GRP_BIT];
        c.high_digit_group = h[TC_HIGH_GRP_BIT];
        c.digit_position_line = 8'(8'h01 << v);
      end
    end
    mct_decode = c;
  endfunction

  // next-state logic
  always_comb begin
    logic p1_in;
    logic p2_in;
    logic p3_in;
    logic fire;
    logic act;
    logic [1:0] wa;
    logic [1:0] ra;
    p1_in = 1'b0;
    p2_in = 1'b0;
    p3_in = 1'b0;
    fire = 1'b0;
    act = st_r.act_s2;
    wa = st_r.aw_addr[3:2];
    ra = s_axi_araddr[3:2];
    st_nxt = st_r;

    // two-flop synchronisers for the pins
    st_nxt.instr_s1 = instr_lines;
    st_nxt.instr_s2 = st_r.instr_s1;
    st_nxt.strb_s1 = translator_load_strobe;
    st_nxt.strb_s2 = st_r.strb_s1;
    st_nxt.strb_d = st_r.strb_s2;
    st_nxt.act_s1 = active_side_enable;
    st_nxt.act_s2 = st_r.act_s1;

    // phase sequencer shared by both translators
    if (st_r.cnt == PHASE_LAST) begin
      st_nxt.cnt = '0;
      case (st_r.phase)
        PH_ONE: begin
          st_nxt.phase = PH_TWO;
          p2_in = 1'b1;
        end
        PH_TWO: begin
          st_nxt.phase = PH_THREE;
          p3_in = 1'b1;
        end
        default: begin
          st_nxt.phase = PH_ONE;
          p1_in = 1'b1;
        end
      endcase
    end else begin
      st_nxt.cnt = st_r.cnt + 6'h01;
    end

    // each program control has its own translator
    for (int i = 0; i < 2; i++) begin
      if (p1_in) begin
        st_nxt.side[i].blank = 1'b1;
        st_nxt.side[i].win = 1'b0;
        if (st_r.side[i].pend) begin
          st_nxt.side[i].in_reg = st_r.instr_s2[i];
          st_nxt.side[i].loaded = 1'b1;
          st_nxt.side[i].pend = 1'b0;
        end
      end
      // a strobe edge landing on the load cycle is kept, set wins
      if (st_r.strb_s2[i] && !st_r.strb_d[i]) begin
        st_nxt.side[i].pend = 1'b1;
      end
      // clear after a command unless the strobe is still up
      if (p2_in && st_r.side[i].issued && !st_r.strb_s2[i]) begin
        st_nxt.side[i].in_reg = '0;
        st_nxt.side[i].loaded = 1'b0;
        st_nxt.side[i].issued = 1'b0;
      end
      if (p3_in) begin
        st_nxt.side[i].blank = 1'b0;
        if (st_r.side[i].loaded && !st_r.side[i].issued) begin
          st_nxt.side[i].win = 1'b1;
          st_nxt.side[i].issued = 1'b1;
        end
      end
    end

    // bookkeeping for the active side only
    if (p3_in && st_r.side[act].loaded && !st_r.side[act].issued) begin
      fire = 1'b1;
    end
    if (fire) begin
      st_nxt.last_code = {act, st_r.side[act].in_reg};
      if (mct_is_impl(st_r.side[act].in_reg)) begin
        st_nxt.cnt_issued = st_r.cnt_issued + 16'h0001;
      end else begin
        st_nxt.cnt_reject = st_r.cnt_reject + 16'h0001;
      end
    end

    // outputs live only in the window of the active side
    if (st_nxt.side[act].win && !st_nxt.side[act].blank && st_r.ctrl_en) begin
      st_nxt.cmd = mct_decode(st_nxt.side[act].in_reg);
    end else begin
      st_nxt.cmd = '0;
    end

    // write address and data channels, taken in either order
    if (st_r.aw_rdy && s_axi_awvalid) begin
      st_nxt.aw_rdy = 1'b0;
      st_nxt.have_aw = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (st_r.w_rdy && s_axi_wvalid) begin
      st_nxt.w_rdy = 1'b0;
      st_nxt.have_w = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    // perform the write once both halves are held
    if (st_r.have_aw && st_r.have_w && !st_r.bvalid) begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case ({wa, 2'b00})
        ADDR_CTRL: begin
          if (st_r.wstrb[0]) begin
            st_nxt.ctrl_en = st_r.wdata[0];
          end
        end
        ADDR_COUNT: begin
          // any write clears both counters; a same-cycle event is lost here by design
          st_nxt.cnt_issued = '0;
          st_nxt.cnt_reject = '0;
        end
        ADDR_STATUS, ADDR_LASTCMD: begin
          st_nxt.bresp = RESP_OKAY; // read-only, write ignored
        end
        default: begin
          st_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    // response accepted, reopen both channels
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
      st_nxt.have_aw = 1'b0;
      st_nxt.have_w = 1'b0;
      st_nxt.aw_rdy = 1'b1;
      st_nxt.w_rdy = 1'b1;
    end

    // read channel
    if (st_r.ar_rdy && s_axi_arvalid) begin
      st_nxt.ar_rdy = 1'b0;
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      st_nxt.rdata = '0;
      case ({ra, 2'b00})
        ADDR_CTRL: begin
          st_nxt.rdata[0] = st_r.ctrl_en;
        end
        ADDR_STATUS: begin
          st_nxt.rdata[STAT_IN0_LSB +: 9] = st_r.side[0].in_reg;
          st_nxt.rdata[STAT_IN1_LSB +: 9] = st_r.side[1].in_reg;
          st_nxt.rdata[STAT_FLAG0_LSB +: 4] = {st_r.side[0].win, st_r.side[0].blank,
                                               st_r.side[0].loaded, st_r.side[0].pend};
          st_nxt.rdata[STAT_FLAG1_LSB +: 4] = {st_r.side[1].win, st_r.side[1].blank,
                                               st_r.side[1].loaded, st_r.side[1].pend};
          st_nxt.rdata[STAT_PHASE_LSB +: 2] = st_r.phase;
          st_nxt.rdata[STAT_SIDE_BIT] = st_r.act_s2;
        end
        ADDR_LASTCMD: begin
          st_nxt.rdata[9:0] = st_r.last_code;
        end
        ADDR_COUNT: begin
          st_nxt.rdata[COUNT_REJ_LSB +: 16] = st_r.cnt_reject;
          st_nxt.rdata[15:0] = st_r.cnt_issued;
        end
        default: begin
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
      st_nxt.ar_rdy = 1'b1;
    end
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.phase <= PH_ONE;
      st_r.ctrl_en <= CTRL_EN_RST;
      st_r.aw_rdy <= 1'b1;
      st_r.w_rdy <= 1'b1;
      st_r.ar_rdy <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from state flops
  assign cmd = st_r.cmd;
  assign s_axi_awready = st_r.aw_rdy;
  assign s_axi_wready = st_r.w_rdy;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_arready = st_r.ar_rdy;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rdata = st_r.rdata;

endmodule
`default_nettype wire

// [test/mct_translator_properties.sv]
// assertions on the translator command outputs
`default_nettype none
module mct_translator_properties
  import mct_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire mct_cmd_t cmd
);
  // one clock domain, reset disables all
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  cmd_quiet_a: assert property (!cmd.valid |-> cmd == '0)
    else $error("cmd lines active outside window");
  win_len_a: assert property ($rose(cmd.valid) |-> ##39 cmd.valid ##1 !cmd.valid)
    else $error("command window length wrong");
  blank_gap_a: assert property ($fell(cmd.valid) |-> !cmd.valid throughout ##79 1'b1)
    else $error("command inside blanking span");
  win_hold_a: assert property (cmd.valid ##1 cmd.valid |-> $stable(cmd))
    else $error("command changed inside window");
  one_target_a: assert property (cmd.valid |-> $onehot(cmd.target))
    else $error("target not one-hot");
  any_digit_a: assert property (cmd.any_digit_select == (cmd.tone_digit_select | cmd.pulse_digit_select))
    else $error("any-digit select wrong");
  digit_form_a: assert property (cmd.target[4] |-> cmd.tone_digit_select != cmd.pulse_digit_select
    && cmd.low_digit_group != cmd.high_digit_group && cmd.digit_position_line == 8'h01 << cmd.ver)
    else $error("digit lines malformed");
  no_unimpl_a: assert property ((cmd.target[3] |-> cmd.hor < ALARM_H_LIMIT)
    and (cmd.target[4] |-> cmd.hor < TESTCALL_H_LIMIT))
    else $error("unimplemented point fired");
  timer_adv_a: assert property (cmd.timer_advance |-> cmd.target[1] && cmd.hor == TIMER_ADV_H
    && cmd.ver == TIMER_ADV_V)
    else $error("timer advance on wrong point");
endmodule
`default_nettype wire

// [test/mct_pc_model.sv]
// program control side: shift register lines and load strobe
`default_nettype none
module mct_pc_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [8:0] code,
  output logic [8:0] lines,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0; // cycles since strobe rose
  initial lines = '0;
  initial strobe = 1'b0;
  // word set with a short positive strobe, then held until the load is long over
  always @(posedge aclk) begin
    if (go) begin
      lines <= code;
      strobe <= 1'b1;
      cnt <= 1;
    end else if (cnt > 0) begin
      cnt <= cnt + 1;
      // strobe drops early, so the later phase-two clear is not blocked
      if (cnt == 8) strobe <= 1'b0;
      // hold over: lines show a changed pattern, never the old word
      if (cnt == 200) begin
        lines <= ~lines;
        cnt <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// [test/tb_mct_translator.sv]
// self-checking bench for the command translator pair
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin err_total++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb_mct_translator
  import mct_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 0, aresetn = 0, active = 0; // active selects the issuing side
  logic [1:0][8:0] lines, code_in = '0;
  logic [1:0] strobe, go = '0;
  mct_cmd_t cmd, ex;
  logic [3:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, awr, wr, bv, arr, rv, prev_v = 0;
  logic [1:0] bresp, rresp, wr_resp; // wr_resp: response of the last write
  int err_total = 0, n_tests = 0;
  mct_cmd_t expq[$]; // expected commands, oldest first
  logic [31:0] lfsr = 32'h29d5;
  // directed codes: every target, every digit form, rejected points
  localparam logic [8:0] TBL [12] = '{9'h000, 9'h040, 9'h0bf, 9'h0e7, 9'h0e8, 9'h100,
    9'h10f, 9'h112, 9'h11a, 9'h127, 9'h140, 9'h1ff};
  mct_translator mct_translator_inst (.aclk(aclk), .aresetn(aresetn), .instr_lines(lines),
    .translator_load_strobe(strobe), .active_side_enable(active), .cmd(cmd),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry));
  // one program control per translator
  for (genvar s = 0; s < 2; s++) begin : g_pc
    mct_pc_model mct_pc_model_inst (.aclk(aclk), .go(go[s]), .code(code_in[s]), .lines(lines[s]),
      .strobe(strobe[s]));
  end
  // 40 mhz clock
  initial forever #12.5 aclk = ~aclk;
  function automatic logic [31:0] lfsr_nx(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // implemented points of the matrix
  function automatic logic impl(input logic [8:0] c);
    return c[8:6] < GRP_ALARM || (c[8:6] == GRP_ALARM && c[5:3] < ALARM_H_LIMIT)
      || (c[8:6] == GRP_TESTCALL && c[5:3] < TESTCALL_H_LIMIT);
  endfunction
  // expected decoded bundle for one code
  function automatic mct_cmd_t exp_of(input logic [8:0] c);
    mct_cmd_t e;
    e = '0;
    e.valid = 1'b1;
    e.target = 5'h01 << c[8:6];
    e.hor = c[5:3];
    e.ver = c[2:0];
    e.timer_advance = c[8:6] == GRP_TIMER && c[5:3] == TIMER_ADV_H && c[2:0] == TIMER_ADV_V;
    if (c[8:6] == GRP_TESTCALL) begin
      e.tone_digit_select = c[HOR_LSB + TC_TONE_BIT];
      e.pulse_digit_select = !c[HOR_LSB + TC_TONE_BIT];
      e.any_digit_select = 1'b1;
      e.high_digit_group = c[HOR_LSB + TC_HIGH_GRP_BIT];
      e.low_digit_group = !c[HOR_LSB + TC_HIGH_GRP_BIT];
      e.digit_position_line = 8'h01 << c[2:0];
    end
    return e;
  endfunction
  // write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    wr_resp = bresp;
    bry <= 1'b0;
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rd;
    r = rresp;
    rry <= 1'b0;
  endtask
  // one instruction from one side; long enough for load, blank, window and clear
  task automatic fire(input int s, input logic [8:0] c, input logic shown);
    if (shown) expq.push_back(exp_of(c));
    @(posedge aclk);
    code_in[s] <= c;
    go[s] <= 1'b1;
    @(posedge aclk);
    go[s] <= 1'b0;
    repeat (300) @(posedge aclk);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // watcher: each new window takes the oldest note
  always @(negedge aclk) begin
    prev_v <= cmd.valid;
    if (cmd.valid === 1'b1 && prev_v !== 1'b1) begin
      if (expq.size() == 0) ex = '0;
      else ex = expq.pop_front();
      `CHK("cmd", ex, cmd)
    end
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    close_out();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [8:0] c, last;
    int imp, rej;
    imp = 0;
    rej = 0;
    last = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADDR_CTRL, d, r);
    `CHK("ctrl reset", 32'h1, d)
    // only address bits 3:2 are decoded, so an unaligned address aliases its word
    axi_rd(4'h2, d, r);
    `CHK("alias resp", RESP_OKAY, r)
    `CHK("alias data", 32'h1, d)
    axi_wr(ADDR_COUNT, 32'h0);
    `CHK("write resp", RESP_OKAY, wr_resp)
    $display("test regs done");
    for (int i = 0; i < 15; i++) begin
      lfsr = lfsr_nx(lfsr);
      c = i < 12 ? TBL[i] : {2'b00, lfsr[6:0]};
      if (impl(c)) last = c;
      if (impl(c)) imp++;
      else rej++;
      fire(0, c, impl(c));
    end
    axi_rd(ADDR_COUNT, d, r);
    `CHK("count", {16'(rej), 16'(imp)}, d)
    axi_rd(ADDR_LASTCMD, d, r);
    `CHK("lastcmd", {23'h0, last}, d)
    // both input registers must be empty again once the last command has gone
    axi_rd(ADDR_STATUS, d, r);
    `CHK("inputs cleared", 18'h0, d[17:0])
    `CHK("side seen", 1'b0, d[STAT_SIDE_BIT])
    $display("test decode done");
    axi_wr(ADDR_CTRL, 32'h0);
    fire(0, 9'h000, 1'b0);
    axi_wr(ADDR_CTRL, 32'h1);
    fire(1, 9'h0a5, 1'b0);
    active <= 1'b1;
    fire(1, 9'h04d, 1'b1);
    axi_rd(ADDR_LASTCMD, d, r);
    `CHK("lastcmd side", {22'h0, 1'b1, 9'h04d}, d)
    `CHK("pending", 0, expq.size())
    $display("test sides done");
    close_out();
  end
endmodule
bind mct_translator mct_translator_properties mct_translator_properties_inst (.aclk(aclk), .aresetn(aresetn),
  .cmd(cmd));
`default_nettype wire
